// >>> fsg_guard.sv
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "fsg_defs.svh"

// Contract
// - With batch-erase security set, every erase request is rejected.
// - With erase locked, writes may only clear bits still erased.
// - With boot-cluster security set, any new request to rewrite boot cluster 0 is rejected.
// - Serial receive baud is measured from reset command after mode pin pulses.
// - Pending unmasked interrupt request stops self-programming at once.
// - Unmasked request stops it even with interrupts disabled.
module fsg_guard
  import fsg_pkg::*;
#(
  parameter int AW        = 16,
  parameter int DW        = 8,
  parameter int BOOT_SIZE = 16'h1000,
  parameter int BW        = 16
) (
  input  wire logic          ref_clk,
  input  wire logic          rst_b,
  input  wire logic [3:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic          flash_mode_pin,
  input  wire logic          prog_rx,
  input  wire logic          boot_swap_active,
  input  wire logic [7:0]    irq_request_flags_0_low,
  input  wire logic [7:0]    irq_request_flags_0_high,
  input  wire logic [7:0]    irq_request_flags_1_low,
  input  wire logic [7:0]    irq_request_flags_1_high,
  input  wire logic [7:0]    irq_mask_flags_0_low,
  input  wire logic [7:0]    irq_mask_flags_0_high,
  input  wire logic [7:0]    irq_mask_flags_1_low,
  input  wire logic [7:0]    irq_mask_flags_1_high,
  output logic [AW-1:0]      flash_addr,
  output logic [DW-1:0]      flash_wdata,
  input  wire logic [DW-1:0] flash_rdata,
  output logic               flash_erase,
  output logic               flash_program,
  output logic               busy,
  output logic               irq
);

  typedef struct packed {
    fsg_state_t             st;
    fsg_op_t                op;
    logic [AW-1:0]          addr;
    logic [DW-1:0]          data;
    logic [7:0]             cnt;
    logic [1:0]             sec;
    logic [`FSG_EV_W-1:0]   status;
    logic [`FSG_EV_W-1:0]   mask;
    logic [31:0]            rdata;
    logic                   ack;
    logic                   erase;
    logic                   prog;
  } fsg_guard_s_t;

  fsg_guard_s_t s_q;
  fsg_guard_s_t s_d;

  logic [BW-1:0] baud_div;
  logic          baud_locked;
  logic          baud_event;
  logic [31:0]   irq_req;
  logic [31:0]   irq_msk;
  logic          irq_stop;
  logic          wr_go;
  fsg_op_t       wr_op;
  logic          reject;
  logic [`FSG_EV_W-1:0] ev;

  //////////////////////////////////////////////////////////////////////////////
  fsg_baud #(
    .W (BW)
  ) u_baud (
    .ref_clk        (ref_clk),
    .rst_b          (rst_b),
    .flash_mode_pin (flash_mode_pin),
    .prog_rx        (prog_rx),
    .baud_div       (baud_div),
    .baud_locked    (baud_locked),
    .baud_event     (baud_event)
  );

  //////////////////////////////////////////////////////////////////////////////
  // True when an address falls in boot cluster 0
  function automatic logic in_boot(input logic [AW-1:0] a);
    return a < AW'(BOOT_SIZE);
  endfunction

  // Would programming need a 0 to become 1 (needs erase)
  function automatic logic needs_erase(input logic [DW-1:0] cur, input logic [DW-1:0] nw);
    return |(nw & ~cur);
  endfunction

  // Interrupt stop ignores the global disable; only per-source masks count
  assign irq_req  = {irq_request_flags_1_high, irq_request_flags_1_low,
                     irq_request_flags_0_high, irq_request_flags_0_low};
  assign irq_msk  = {irq_mask_flags_1_high, irq_mask_flags_1_low,
                     irq_mask_flags_0_high, irq_mask_flags_0_low};
  assign irq_stop = |(irq_req & ~irq_msk);

  assign wr_go = avs_write && !s_q.ack && avs_address == `FSG_OFF_CTRL && avs_byteenable[0]
                 && avs_writedata[`FSG_CTRL_GO_BIT];
  assign wr_op = fsg_op_t'(avs_writedata[`FSG_CTRL_OP_LSB +: 2]);

  // Security screening of a new request
  always_comb begin
    reject = 1'b0;
    if (wr_op != FSG_OP_WRITE && s_q.sec[`FSG_SEC_ERASE_BIT]) begin
      reject = 1'b1;
    end
    if (s_q.sec[`FSG_SEC_BOOT_BIT] && in_boot(avs_writedata[`FSG_CTRL_ADDR_LSB +: AW])) begin
      reject = 1'b1;
    end
    if (wr_op == FSG_OP_EPV && boot_swap_active) begin
      reject = 1'b1;
    end
    if (s_q.st != FSG_ST_IDLE || !flash_mode_pin || irq_stop) begin
      reject = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave, sequencer and events
  always_comb begin
    s_d       = s_q;
    s_d.ack   = 1'b0;
    s_d.erase = 1'b0;
    s_d.prog  = 1'b0;
    ev        = '0;
    // One wait cycle: answer on the second edge of each access
    if ((avs_read || avs_write) && !s_q.ack) begin
      s_d.ack = 1'b1;
      unique case (avs_address)
        `FSG_OFF_CTRL:   s_d.rdata = {30'h0, busy, baud_locked};
        `FSG_OFF_STATUS: s_d.rdata = {{(32-`FSG_EV_W){1'b0}}, s_q.status};
        `FSG_OFF_MASK:   s_d.rdata = {{(32-`FSG_EV_W){1'b0}}, s_q.mask};
        `FSG_OFF_SECURE: s_d.rdata = {30'h0, s_q.sec};
        default:         s_d.rdata = 32'h0;
      endcase
      if (avs_read && avs_address == `FSG_OFF_SECURE) begin
        s_d.rdata = {{(32-BW){1'b0}}, baud_div} << 16 | {30'h0, s_q.sec};
      end
      if (avs_write && avs_byteenable[0]) begin
        if (avs_address == `FSG_OFF_MASK) begin
          s_d.mask = avs_writedata[`FSG_EV_W-1:0];
        end
        // Security bits are sticky: they can be set but never cleared
        if (avs_address == `FSG_OFF_SECURE) begin
          s_d.sec = s_q.sec | avs_writedata[1:0];
        end
      end
      if (wr_go) begin
        if (reject) begin
          ev[`FSG_EV_REJECT] = 1'b1;
        end else begin
          s_d.st   = FSG_ST_BUSY;
          s_d.op   = wr_op;
          s_d.addr = avs_writedata[`FSG_CTRL_ADDR_LSB +: AW];
          s_d.data = avs_writedata[24 +: DW];
          s_d.cnt  = 8'(`FSG_OP_CYC);
        end
      end
    end
    unique case (s_q.st)
      FSG_ST_IDLE: begin
      end
      FSG_ST_BUSY: begin
        if (irq_stop || !flash_mode_pin) begin
          s_d.st = FSG_ST_ABORT;
        end else if (s_q.op != FSG_OP_WRITE && s_q.sec[`FSG_SEC_ERASE_BIT]) begin
          // Lock set after GO still stops an erase already in flight
          s_d.st = FSG_ST_IDLE;
          ev[`FSG_EV_REJECT] = 1'b1;
        end else if (s_q.op == FSG_OP_WRITE && s_q.sec[`FSG_SEC_ERASE_BIT]
                     && needs_erase(flash_rdata, s_q.data)) begin
          s_d.st = FSG_ST_IDLE;
          ev[`FSG_EV_REJECT] = 1'b1;
        end else if (s_q.cnt == 8'h1) begin
          s_d.erase = s_q.op != FSG_OP_WRITE;
          s_d.prog  = s_q.op != FSG_OP_ERASE;
          s_d.st    = FSG_ST_IDLE;
          ev[`FSG_EV_DONE] = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 8'h1;
        end
      end
      FSG_ST_ABORT: begin
        s_d.st = FSG_ST_IDLE;
        ev[`FSG_EV_ABORT] = 1'b1;
      end
      default: s_d.st = FSG_ST_IDLE;
    endcase
    ev[`FSG_EV_BAUD] = baud_event;
    // Read clears, but a same-cycle event survives
    if (avs_read && !s_q.ack && avs_address == `FSG_OFF_STATUS) begin
      s_d.status = ev;
    end else begin
      s_d.status = s_q.status | ev;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q      <= '0;
      s_q.mask <= `FSG_MASK_RST;
      s_q.sec  <= `FSG_SEC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
  assign avs_readdata    = s_q.rdata;
  assign flash_addr      = s_q.addr;
  assign flash_wdata     = s_q.data;
  assign flash_erase     = s_q.erase;
  assign flash_program   = s_q.prog;
  assign busy            = s_q.st != FSG_ST_IDLE;
  assign irq             = |(s_q.status & s_q.mask);

  //////////////////////////////////////////////////////////////////////////////
  property p_no_erase_locked;
    @(posedge ref_clk) disable iff (!rst_b)
      s_q.sec[`FSG_SEC_ERASE_BIT] && $past(s_q.sec[`FSG_SEC_ERASE_BIT]) |-> !flash_erase;
  endproperty
  a_no_erase_locked: assert property (p_no_erase_locked)
    else $error("erase issued while erase locked");

  property p_no_flip_up;
    @(posedge ref_clk) disable iff (!rst_b)
      (s_q.st == FSG_ST_BUSY && s_q.op == FSG_OP_WRITE && s_q.sec[`FSG_SEC_ERASE_BIT]
       && !irq_stop && flash_mode_pin && needs_erase(flash_rdata, s_q.data)) |=> !flash_program && !busy;
  endproperty
  a_no_flip_up: assert property (p_no_flip_up)
    else $error("locked write altered programmed bits");

  property p_boot_guard;
    @(posedge ref_clk) disable iff (!rst_b)
      (flash_erase || flash_program) && $past(s_q.sec[`FSG_SEC_BOOT_BIT], `FSG_OP_CYC + 1)
      |-> !in_boot(flash_addr);
  endproperty
  a_boot_guard: assert property (p_boot_guard)
    else $error("boot cluster rewritten under security");

  property p_irq_stop;
    @(posedge ref_clk) disable iff (!rst_b)
      (s_q.st == FSG_ST_BUSY && irq_stop) |=> s_q.st == FSG_ST_ABORT ##1 !busy;
  endproperty
  a_irq_stop: assert property (p_irq_stop)
    else $error("self-programming not stopped by interrupt request");

  property p_masked_runs;
    @(posedge ref_clk) disable iff (!rst_b)
      (s_q.st == FSG_ST_BUSY && !irq_stop && flash_mode_pin && s_q.cnt > 8'h1 && !s_q.sec[0])
      |=> s_q.st == FSG_ST_BUSY;
  endproperty
  a_masked_runs: assert property (p_masked_runs)
    else $error("masked requests stopped self-programming");

  property p_no_epv_swap;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_go && wr_op == FSG_OP_EPV && boot_swap_active) |=> s_q.status[`FSG_EV_REJECT];
  endproperty
  a_no_epv_swap: assert property (p_no_epv_swap)
    else $error("erase-program-verify accepted during boot swap");

  property p_erase_lock_go;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_go && wr_op != FSG_OP_WRITE && s_q.sec[`FSG_SEC_ERASE_BIT]) |=> s_q.status[`FSG_EV_REJECT];
  endproperty
  a_erase_lock_go: assert property (p_erase_lock_go)
    else $error("erase request accepted while erase locked");

  property p_boot_lock_go;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_go && s_q.sec[`FSG_SEC_BOOT_BIT] && in_boot(avs_writedata[`FSG_CTRL_ADDR_LSB +: AW]))
      |=> s_q.status[`FSG_EV_REJECT];
  endproperty
  a_boot_lock_go: assert property (p_boot_lock_go)
    else $error("boot cluster request accepted while boot locked");

  property p_mode_pin;
    @(posedge ref_clk) disable iff (!rst_b)
      (busy && !flash_mode_pin) |-> ##[1:2] !busy;
  endproperty
  a_mode_pin: assert property (p_mode_pin)
    else $error("operation continued with mode pin low");

  property p_irq_level;
    @(posedge ref_clk) disable iff (!rst_b)
      irq == |(s_q.status & s_q.mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output mismatch");

endmodule

// >>> fsg_defs.svh
`ifndef FSG_DEFS_SVH
`define FSG_DEFS_SVH

// Register byte offsets
`define FSG_OFF_CTRL    4'h0
`define FSG_OFF_STATUS  4'h4
`define FSG_OFF_MASK    4'h8
`define FSG_OFF_SECURE  4'hC

// Control register fields
`define FSG_CTRL_GO_BIT    0
`define FSG_CTRL_OP_LSB    1
`define FSG_CTRL_ADDR_LSB  8

// Security register fields
`define FSG_SEC_ERASE_BIT  0
`define FSG_SEC_BOOT_BIT   1

// Event status bits
`define FSG_EV_DONE     0
`define FSG_EV_ABORT    1
`define FSG_EV_REJECT   2
`define FSG_EV_BAUD     3
`define FSG_EV_W        4

// Reset values
`define FSG_MASK_RST    4'h0
`define FSG_SEC_RST     2'h0

// Timing
`define FSG_CLK_NS      100
`define FSG_OP_NS       800
`define FSG_OP_CYC      ((`FSG_OP_NS + `FSG_CLK_NS - 1) / `FSG_CLK_NS)
`define FSG_PULSES      3

`endif

// >>> fsg_pkg.sv
package fsg_pkg;
  typedef enum logic [1:0] {
    FSG_OP_WRITE,
    FSG_OP_ERASE,
    FSG_OP_EPV
  } fsg_op_t;

  typedef enum logic [2:0] {
    FSG_ST_IDLE,
    FSG_ST_BUSY,
    FSG_ST_ABORT
  } fsg_state_t;

  typedef enum logic [1:0] {
    FSG_BD_WAIT_PULSE,
    FSG_BD_WAIT_START,
    FSG_BD_MEASURE,
    FSG_BD_LOCKED
  } fsg_baud_state_t;
endpackage

// >>> fsg_baud.sv
`timescale 1ns/1ns
`include "fsg_defs.svh"

// Baud measurement on the programming serial input
module fsg_baud
  import fsg_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         flash_mode_pin,
  input  wire logic         prog_rx,
  output logic [W-1:0]      baud_div,
  output logic              baud_locked,
  output logic              baud_event
);

  typedef struct packed {
    fsg_baud_state_t st;
    logic [3:0]      pulses;
    logic            mode_last;
    logic            rx_last;
    logic [W-1:0]    cnt;
    logic [W-1:0]    div;
    logic            ev;
  } fsg_baud_s_t;

  fsg_baud_s_t s_q;
  fsg_baud_s_t s_d;

  //////////////////////////////////////////////////////////////////////////////
  // Pulse count, then time the low start bit of the reset command
  always_comb begin
    s_d           = s_q;
    s_d.mode_last = flash_mode_pin;
    s_d.rx_last   = prog_rx;
    s_d.ev        = 1'b0;
    unique case (s_q.st)
      FSG_BD_WAIT_PULSE: begin
        if (flash_mode_pin && !s_q.mode_last) begin
          s_d.pulses = s_q.pulses + 4'h1;
          if (s_q.pulses == 4'(`FSG_PULSES - 1)) begin
            s_d.st = FSG_BD_WAIT_START;
          end
        end
      end
      FSG_BD_WAIT_START: begin
        if (!prog_rx && s_q.rx_last) begin
          s_d.st  = FSG_BD_MEASURE;
          s_d.cnt = {{(W-1){1'b0}}, 1'b1};
        end
      end
      FSG_BD_MEASURE: begin
        // Saturate rather than wrap on a stuck line
        if (!prog_rx && s_q.cnt != {W{1'b1}}) begin
          s_d.cnt = s_q.cnt + {{(W-1){1'b0}}, 1'b1};
        end else if (prog_rx) begin
          s_d.div = s_q.cnt;
          s_d.st  = FSG_BD_LOCKED;
          s_d.ev  = 1'b1;
        end
      end
      FSG_BD_LOCKED: begin
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign baud_div    = s_q.div;
  assign baud_locked = s_q.st == FSG_BD_LOCKED;
  assign baud_event  = s_q.ev;

  property p_baud_only_after_pulses;
    @(posedge ref_clk) disable iff (!rst_b)
      $rose(baud_locked) |-> $past(s_q.pulses) == 4'(`FSG_PULSES);
  endproperty
  a_baud_only_after_pulses: assert property (p_baud_only_after_pulses)
    else $error("baud locked before mode pin pulses");

  property p_baud_width;
    @(posedge ref_clk) disable iff (!rst_b)
      (s_q.st == FSG_BD_MEASURE && prog_rx) |=> baud_div == $past(s_q.cnt) && baud_event;
  endproperty
  a_baud_width: assert property (p_baud_width)
    else $error("baud divisor not taken from start bit width");

endmodule

// >>> fsg_prog_model.sv
`timescale 1ns/1ns

// Stand-in for the serial programmer and the flash array behind the guard
module fsg_prog_model #(
  parameter int LOW_CYC = 12
) (
  input  wire logic        ref_clk,
  input  wire logic        send_cmd,
  input  wire logic        mode_hold,
  input  wire logic [15:0] flash_addr,
  input  wire logic [7:0]  flash_wdata,
  input  wire logic        flash_erase,
  input  wire logic        flash_program,
  output logic [7:0]       flash_rdata,
  output logic             flash_mode_pin,
  output logic             prog_rx,
  output logic             cmd_done
);
  logic [7:0] mem [0:255];
  logic       mode_q;

  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end

  // Bench may pull the pin low mid-run to model a system that breaks the hold
  assign flash_mode_pin = mode_q && mode_hold;

  ////////////////////////////////////////////////////////////////////////////
  // Three mode pin pulses, last one left high, then the low start of the reset command
  initial begin
    mode_q   = 1'b0;
    prog_rx  = 1'b1;
    cmd_done = 1'b0;
    forever begin
      @(posedge send_cmd);
      for (int i = 0; i < 3; i++) begin
        mode_q <= 1'b1;
        repeat (2) @(posedge ref_clk);
        mode_q <= (i == 2);
        repeat (2) @(posedge ref_clk);
      end
      prog_rx <= 1'b0;
      repeat (LOW_CYC) @(posedge ref_clk);
      prog_rx <= 1'b1;
      repeat (4) @(posedge ref_clk);
      cmd_done <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array: program can only clear bits, which is what makes the erase lock bite
  assign flash_rdata = mem[flash_addr[7:0]];
  always @(posedge ref_clk) begin
    if (flash_erase) begin
      mem[flash_addr[7:0]] <= flash_program ? flash_wdata : 8'hFF;
    end else if (flash_program) begin
      mem[flash_addr[7:0]] <= mem[flash_addr[7:0]] & flash_wdata;
    end
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ns

module tb_top
  import fsg_pkg::*;
;
  logic        ref_clk, rst_b, avs_read, avs_write, boot_swap_active, send_cmd;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        avs_waitrequest, flash_mode_pin, prog_rx, flash_erase, flash_program, busy, irq, cmd_done;
  logic [7:0]  req_0_lo, req_0_hi, req_1_lo, req_1_hi, msk_0_lo, msk_0_hi, msk_1_lo, msk_1_hi;
  logic [7:0]  flash_wdata, flash_rdata, mask_v;
  logic        mode_hold, cpu_irq_disabled;
  logic [15:0] flash_addr;
  int          bad_count, total_checks, cyc_count;

  fsg_guard DUT (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flash_mode_pin(flash_mode_pin),
    .prog_rx(prog_rx), .boot_swap_active(boot_swap_active), .irq_request_flags_0_low(req_0_lo),
    .irq_request_flags_0_high(req_0_hi), .irq_request_flags_1_low(req_1_lo), .irq_request_flags_1_high(req_1_hi),
    .irq_mask_flags_0_low(msk_0_lo), .irq_mask_flags_0_high(msk_0_hi), .irq_mask_flags_1_low(msk_1_lo),
    .irq_mask_flags_1_high(msk_1_hi), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_rdata(flash_rdata), .flash_erase(flash_erase), .flash_program(flash_program),
    .busy(busy), .irq(irq));

  fsg_prog_model #(.LOW_CYC(12)) u_model (.ref_clk(ref_clk), .send_cmd(send_cmd), .mode_hold(mode_hold),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_erase(flash_erase), .flash_program(flash_program),
    .flash_rdata(flash_rdata), .flash_mode_pin(flash_mode_pin), .prog_rx(prog_rx), .cmd_done(cmd_done));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, and a ceiling well above the few hundred cycles the tests need
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc_count++;
    if (cyc_count == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon access; request held until waitrequest is sampled low
  task automatic avs_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 100) check("waitrequest", 32'h1, 32'h0);
  endtask

  // Start an operation, optionally raise a request mid-run, then judge status, irq and array
  task automatic run_op(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d,
                        input logic inject, input logic [31:0] exp_st, input logic [7:0] exp_mem);
    int n;
    n = 0;
    cpu_irq_disabled <= 1'b1;
    avs_xfer(1'b1, 4'h0, {d, a, 5'h00, op, 1'b1});
    repeat (2) @(posedge ref_clk);
    if (inject && cpu_irq_disabled) req_1_hi <= 8'h80;
    while (busy !== 1'b0 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    cpu_irq_disabled <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("irq_before", {31'h0, irq}, {31'h0, |(exp_st[7:0] & mask_v)});
    avs_xfer(1'b0, 4'h4, 32'h0);
    check("status", rd, exp_st);
    check("array", {24'h0, u_model.mem[a[7:0]]}, {24'h0, exp_mem});
    repeat (2) @(posedge ref_clk);
    check("irq_after", {31'h0, irq}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_vals();
    avs_xfer(1'b0, 4'h8, 32'h0);
    check("mask_rst", rd, 32'h0);
    avs_xfer(1'b0, 4'hC, 32'h0);
    check("secure_rst", rd, 32'h0);
    avs_xfer(1'b1, 4'h2, 32'hFFFF_FFFF);
    avs_xfer(1'b0, 4'h2, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("test reset_vals done");
  endtask

  task automatic t_baud();
    int n;
    n = 0;
    send_cmd <= 1'b1;
    while (cmd_done !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    avs_xfer(1'b0, 4'hC, 32'h0);
    check("baud_div", rd, 32'h000C_0000);
    avs_xfer(1'b0, 4'h0, 32'h0);
    check("baud_locked", rd, 32'h1);
    avs_xfer(1'b0, 4'h4, 32'h0);
    check("baud_event", rd, 32'h8);
    $display("test baud done");
  endtask

  task automatic t_ops_irq();
    mask_v = 8'h01;
    avs_xfer(1'b1, 4'h8, 32'h1);
    run_op(FSG_OP_WRITE, 16'h2010, 8'h5A, 1'b0, 32'h1, 8'h5A);
    boot_swap_active <= 1'b0;
    run_op(FSG_OP_EPV, 16'h2040, 8'h3C, 1'b0, 32'h1, 8'h3C);
    // Guard refuses the combined command during a swap even if a programmer tries
    boot_swap_active <= 1'b1;
    run_op(FSG_OP_EPV, 16'h2040, 8'h00, 1'b0, 32'h4, 8'h3C);
    boot_swap_active <= 1'b0;
    mask_v = 8'h00;
    avs_xfer(1'b1, 4'h8, 32'h0);
    run_op(FSG_OP_ERASE, 16'h2010, 8'h00, 1'b0, 32'h1, 8'hFF);
    run_op(FSG_OP_WRITE, 16'h2010, 8'h5A, 1'b0, 32'h1, 8'h5A);
    $display("test ops_irq done");
  endtask

  task automatic t_abort();
    run_op(FSG_OP_WRITE, 16'h2030, 8'h00, 1'b1, 32'h2, 8'hFF);
    msk_1_hi <= 8'h80;
    run_op(FSG_OP_WRITE, 16'h2030, 8'h00, 1'b0, 32'h1, 8'h00);
    req_1_hi <= 8'h00;
    msk_1_hi <= 8'h00;
    // Mode pin dropped mid-run: the guard must abort rather than finish
    avs_xfer(1'b1, 4'h0, {8'h00, 16'h2050, 5'h00, FSG_OP_WRITE, 1'b1});
    mode_hold <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("mode_drop_busy", {31'h0, busy}, 32'h0);
    mode_hold <= 1'b1;
    avs_xfer(1'b0, 4'h4, 32'h0);
    check("mode_drop_status", rd, 32'h2);
    check("mode_drop_array", {24'h0, u_model.mem[8'h50]}, 32'h0000_00FF);
    $display("test abort done");
  endtask

  task automatic t_security();
    avs_xfer(1'b1, 4'hC, 32'h1);
    run_op(FSG_OP_ERASE, 16'h2010, 8'h00, 1'b0, 32'h4, 8'h5A);
    run_op(FSG_OP_EPV, 16'h2010, 8'hFF, 1'b0, 32'h4, 8'h5A);
    run_op(FSG_OP_WRITE, 16'h2010, 8'h7A, 1'b0, 32'h4, 8'h5A);
    run_op(FSG_OP_WRITE, 16'h2010, 8'h58, 1'b0, 32'h1, 8'h58);
    avs_xfer(1'b1, 4'hC, 32'h2);
    avs_xfer(1'b0, 4'hC, 32'h0);
    check("secure_bits", {30'h0, rd[1:0]}, 32'h3);
    run_op(FSG_OP_WRITE, 16'h0020, 8'h00, 1'b0, 32'h4, 8'hFF);
    run_op(FSG_OP_WRITE, 16'h1000, 8'h00, 1'b0, 32'h1, 8'h00);
    $display("test security done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Closing report, the only place the run ends
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    {avs_read, avs_write, boot_swap_active, send_cmd} = 4'h0;
    avs_address = 4'h0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0;
    {req_0_lo, req_0_hi, req_1_lo, req_1_hi, msk_0_lo, msk_0_hi, msk_1_lo, msk_1_hi, mask_v} = '0;
    mode_hold = 1'b1;
    cpu_irq_disabled = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset_vals();
    t_baud();
    t_ops_irq();
    t_abort();
    t_security();
    give_verdict();
  end
endmodule
